// [axil_write_sink.sv]
// AXI4-Lite write channel slave: takes address and data in either order
`include "ts_store_params.svh"
module axil_write_sink
	import ts_store_pkg::*;
(
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// write address
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [11:0] awaddr,
	// write data
	input  wire logic        wvalid,
	output logic             wready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	// write response
	output logic             bvalid,
	input  wire logic        bready,
	output logic [1:0]       bresp,
	// decoded write toward the register file
	output logic             wr_fire,
	output logic [11:0]      wr_addr,
	output logic [31:0]      wr_data,
	output logic [3:0]       wr_strb,
	input  wire logic        wr_err
);

	wr_state_t s_q;
	wr_state_t s_d;
	logic      aw_take;
	logic      w_take;
	logic      aw_have;
	logic      w_have;

	assign awready = !s_q.aw_got && !s_q.bvalid;
	assign wready  = !s_q.w_got && !s_q.bvalid;
	assign bvalid  = s_q.bvalid;
	assign bresp   = s_q.bresp;
	// halves taken now or held from earlier; no loop through s_d
	assign aw_take = awvalid && awready;
	assign w_take  = wvalid && wready;
	assign aw_have = s_q.aw_got || aw_take;
	assign w_have  = s_q.w_got || w_take;
	assign wr_addr = aw_take ? awaddr : s_q.addr;
	assign wr_data = w_take ? wdata : s_q.data;
	assign wr_strb = w_take ? wstrb : s_q.strb;
	assign wr_fire = aw_have && w_have && !s_q.bvalid;

	always_comb begin
		s_d = s_q;
		if (aw_take) begin
			s_d.aw_got = 1'b1;
			s_d.addr   = awaddr;
		end
		if (w_take) begin
			s_d.w_got = 1'b1;
			s_d.data  = wdata;
			s_d.strb  = wstrb;
		end
		if (wr_fire) begin
			s_d.aw_got = 1'b0;
			s_d.w_got  = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp  = wr_err ? `RESP_SLVERR : `RESP_OKAY;
		end else if (s_q.bvalid && bready) begin
			s_d.bvalid = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

endmodule : axil_write_sink

// [event_timestamp_sample_store.sv]
// readback store for the fifth to seventh event timestamp samples
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`include "ts_store_params.svh"
module event_timestamp_sample_store
	import ts_store_pkg::*;
#(
	parameter int SAMPLES = 3
) (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,

	// write address channel
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [11:0] awaddr,

	// write data channel
	input  wire logic        wvalid,
	output logic             wready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,

	// write response channel
	output logic             bvalid,
	input  wire logic        bready,
	output logic [1:0]       bresp,

	// read address channel
	input  wire logic        arvalid,
	output logic             arready,
	input  wire logic [11:0] araddr,

	// read data channel
	output logic             rvalid,
	input  wire logic        rready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,

	// captures from the engine, fifth, sixth, seventh
	input  wire capture_t    cap_in [SAMPLES],

	// current unit pointer
	output logic             unit_ptr
);

	// register state
	top_state_t s_q;
	top_state_t s_d;

	// write side decode
	logic        wr_fire;
	logic [11:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0]  wr_strb;
	logic        wr_err;
	logic        wr_ptr_hit;

	// readback words per sample
	logic [31:0] ns_w    [SAMPLES];
	logic [31:0] sec_w   [SAMPLES];
	logic [31:0] phase_w [SAMPLES];

	// read decode result
	logic        rd_hit;
	logic [31:0] rd_word;

	// one storage slot per sample; the fifth keeps phase only
	for (genvar g = 0; g < SAMPLES; g++) begin : g_slot
		sample_slot #(
			.HAS_TIME (g != 0)
		) u_slot (
			.aclk       (aclk),
			.aresetn    (aresetn),
			.cap        (cap_in[g]),
			.sel_unit   (s_q.unit_ptr),
			.ns_word    (ns_w[g]),
			.sec_word   (sec_w[g]),
			.phase_word (phase_w[g])
		);
	end

	// write channel
	axil_write_sink u_wr (
		.aclk    (aclk),
		.aresetn (aresetn),
		.awvalid (awvalid),
		.awready (awready),
		.awaddr  (awaddr),
		.wvalid  (wvalid),
		.wready  (wready),
		.wdata   (wdata),
		.wstrb   (wstrb),
		.bvalid  (bvalid),
		.bready  (bready),
		.bresp   (bresp),
		.wr_fire (wr_fire),
		.wr_addr (wr_addr),
		.wr_data (wr_data),
		.wr_strb (wr_strb),
		.wr_err  (wr_err)
	);

	// true when the word address matches a sample register
	function automatic logic is_sample(input logic [11:0] a);
		logic [9:0] w;
		w = a[11:2];
		is_sample = (w == `OFS_S5_PHASE >> 2)
			|| (w == `OFS_S6_NS >> 2)
			|| (w == `OFS_S6_SEC >> 2)
			|| (w == `OFS_S6_PHASE >> 2)
			|| (w == `OFS_S7_NS >> 2)
			|| (w == `OFS_S7_SEC >> 2);
	endfunction : is_sample

	// write decode: only the unit pointer takes data
	always_comb begin
		wr_ptr_hit = (wr_addr[11:2] == `OFS_UNIT_INDEX >> 2);
		wr_err     = !wr_ptr_hit && !is_sample(wr_addr);
	end

	// read decode
	always_comb begin
		rd_hit  = 1'b1;
		rd_word = 32'h0000_0000;
		case (araddr[11:2])
			`OFS_S5_PHASE >> 2: begin
				rd_word = phase_w[0];
			end
			`OFS_S6_NS >> 2: begin
				rd_word = ns_w[1];
			end
			`OFS_S6_SEC >> 2: begin
				rd_word = sec_w[1];
			end
			`OFS_S6_PHASE >> 2: begin
				rd_word = phase_w[1];
			end
			`OFS_S7_NS >> 2: begin
				rd_word = ns_w[2];
			end
			`OFS_S7_SEC >> 2: begin
				rd_word = sec_w[2];
			end
			`OFS_UNIT_INDEX >> 2: begin
				rd_word[`UNIT_PTR_BIT] = s_q.unit_ptr;
			end
			default: begin
				rd_hit = 1'b0;
			end
		endcase
	end

	// handshake outputs
	assign arready  = (s_q.phase == RD_IDLE);
	assign rvalid   = (s_q.phase == RD_RESP);
	assign rdata    = s_q.rdata;
	assign rresp    = s_q.rresp;
	assign unit_ptr = s_q.unit_ptr;

	// next state
	always_comb begin
		s_d = s_q;
		case (s_q.phase)
			RD_IDLE: begin
				if (arvalid) begin
					s_d.phase = RD_RESP;
					s_d.rdata = rd_word;
					s_d.rresp = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
				end
			end
			RD_RESP: begin
				if (rready) begin
					s_d.phase = RD_IDLE;
				end
			end
			default: begin
				s_d.phase = RD_IDLE;
			end
		endcase
		// unit pointer write; sample writes fall through untouched
		if (wr_fire && wr_ptr_hit && wr_strb[`UNIT_PTR_LANE]) begin
			s_d.unit_ptr = wr_data[`UNIT_PTR_BIT];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q.phase    <= RD_IDLE;
			s_q.rdata    <= 32'h0000_0000;
			s_q.rresp    <= `RESP_OKAY;
			s_q.unit_ptr <= `RST_UNIT_PTR;
		end else begin
			s_q <= s_d;
		end
	end

endmodule : event_timestamp_sample_store

// [event_timestamp_sample_store_tb_top.sv]
// self-checking bench for the timestamp sample store
`include "ts_store_params.svh"
module event_timestamp_sample_store_tb_top
	import ts_store_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [1:0]  s;
		logic        u;
		logic        ri;
		logic [29:0] ns;
		logic [31:0] sec;
		logic [2:0]  slot;
		logic [2:0]  code;
	} row_t;
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, unit_ptr;
	logic [11:0] awaddr, araddr, a;
	logic [31:0] wdata, rdata, d;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, r;
	capture_t    cap [3];
	row_t        rows [7];
	int          n_fail, samples_checked;

	event_timestamp_sample_store dut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready,
		.wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready,
		.rdata, .rresp, .cap_in(cap), .unit_ptr);

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : wrap_up

	task automatic chk(input string n, input logic [33:0] s, input logic [33:0] e);
		samples_checked++;
		if (s !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task automatic wr(input logic [11:0] ad, input logic [31:0] dt, output logic [1:0] rs);
		logic aw, w, b;
		awvalid <= 1'b1;
		awaddr <= ad;
		wvalid <= 1'b1;
		wdata <= dt;
		bready <= 1'b1;
		b = 1'b0;
		while (!b) begin
			@(negedge aclk);
			aw = awvalid & awready;
			w = wvalid & wready;
			b = bvalid;
			rs = bresp;
			@(posedge aclk);
			if (aw) awvalid <= 1'b0;
			if (w) wvalid <= 1'b0;
		end
	endtask : wr

	task automatic rd(input logic [11:0] ad, output logic [31:0] dt, output logic [1:0] rs);
		logic t, g;
		arvalid <= 1'b1;
		araddr <= ad;
		rready <= 1'b1;
		g = 1'b0;
		while (!g) begin
			@(negedge aclk);
			t = arvalid & arready;
			g = rvalid;
			dt = rdata;
			rs = rresp;
			@(posedge aclk);
			if (t) arvalid <= 1'b0;
		end
	endtask : rd

	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end

	initial begin
		#100000;
		n_fail++;
		wrap_up();
	end

	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
		wstrb = 4'hF;
		foreach (cap[k]) cap[k] = '0;
		rows = '{'{2'd0, 1'b0, 1'b1, 30'h1, 32'h0, 3'h3, `SLOT_CODE_24NS},
			'{2'd1, 1'b0, 1'b1, 30'h3FFF_FFFF, 32'hFFFF_FFFF, 3'h1, `SLOT_CODE_8NS},
			'{2'd1, 1'b1, 1'b0, 30'h1234_5678, 32'h0000_00A5, 3'h2, `SLOT_CODE_16NS},
			'{2'd2, 1'b1, 1'b1, 30'h0ABC_DEF0, 32'h8000_0001, 3'h0, `SLOT_CODE_0NS},
			'{2'd0, 1'b1, 1'b0, 30'h2, 32'h3, 3'h4, `SLOT_CODE_32NS},
			'{2'd1, 1'b0, 1'b0, 30'h42, 32'h0000_1000, 3'h5, `SLOT_CODE_16NS},
			'{2'd0, 1'b0, 1'b0, 30'h0, 32'h0, 3'h0, `SLOT_CODE_0NS}};
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		for (int i = 0; i < 7; i++) begin
			wr(`OFS_UNIT_INDEX, {23'h0, rows[i].u, 8'h00}, r);
			chk("ptr", {1'b0, unit_ptr}, {1'b0, rows[i].u});
			cap[rows[i].s] <= '{1'b1, rows[i].u, rows[i].ri, rows[i].ns, rows[i].sec, rows[i].slot};
			@(posedge aclk);
			cap[rows[i].s].valid <= 1'b0;
			a = 12'h584 + 12'(12 * rows[i].s);
			if (rows[i].s != 2'd0) begin
				rd(a, d, r);
				chk("ns", {r, d}, {`RESP_OKAY, 1'b0, rows[i].ri, rows[i].ns});
				rd(a + 12'h4, d, r);
				chk("sec", {r, d}, {`RESP_OKAY, rows[i].sec});
			end
			if (rows[i].s != 2'd2) begin
				rd(a + 12'h8, d, r);
				chk("phase", {r, d}, {`RESP_OKAY, 29'h0, rows[i].code});
			end
		end
		// banks kept apart per unit
		wr(`OFS_UNIT_INDEX, 32'h0, r);
		rd(`OFS_S6_NS, d, r);
		chk("bank0", {r, d}, {`RESP_OKAY, 1'b0, rows[5].ri, rows[5].ns});
		wr(`OFS_UNIT_INDEX, 32'h100, r);
		rd(`OFS_S6_NS, d, r);
		chk("bank1", {r, d}, {`RESP_OKAY, 1'b0, rows[2].ri, rows[2].ns});
		rd(`OFS_UNIT_INDEX, d, r);
		chk("unit_reg", {r, d}, {`RESP_OKAY, 32'h100});
		// sample writes answered OKAY but ignored
		wr(`OFS_S6_SEC, 32'hFFFF_FFFF, r);
		chk("ro_wr", {r, 32'h0}, {`RESP_OKAY, 32'h0});
		rd(`OFS_S6_SEC, d, r);
		chk("ro_keep", {r, d}, {`RESP_OKAY, rows[2].sec});
		// read answer held while rready stays low
		rready <= 1'b0;
		arvalid <= 1'b1;
		araddr <= `OFS_S6_SEC;
		@(posedge aclk);
		arvalid <= 1'b0;
		repeat (3) @(posedge aclk);
		@(negedge aclk);
		chk("rd_hold", {1'b0, rvalid, rdata}, {2'b01, rows[2].sec});
		@(posedge aclk);
		rready <= 1'b1;
		@(posedge aclk);
		@(negedge aclk);
		chk("rd_done", {33'h0, rvalid}, 34'h0);
		@(posedge aclk);
		rd(12'h584, d, r);
		chk("unmapped", {r, d}, {`RESP_SLVERR, 32'h0});
		wr(12'h584, 32'h0000_0001, r);
		chk("unmapped_wr", {r, 32'h0}, {`RESP_SLVERR, 32'h0});
		// second reset clears everything
		aresetn <= 1'b0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		chk("ptr_rst", {1'b0, unit_ptr}, 34'h0);
		chk("idle", {29'h0, awready, wready, arready, bvalid, rvalid}, 34'h1C);
		for (int k = 0; k < 6; k++) begin
			rd(`OFS_S5_PHASE + 12'(4 * k), d, r);
			chk("rst_val", {r, d}, {`RESP_OKAY, 32'h0});
		end
		wrap_up();
	end
endmodule : event_timestamp_sample_store_tb_top

// [sample_slot.sv]
// storage of one captured sample; edge, ns and sec banked per timestamp unit, slot code shared
`include "ts_store_params.svh"
module sample_slot
	import ts_store_pkg::*;
#(
	parameter bit HAS_TIME = 1'b1
) (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// capture from the engine
	input  wire capture_t    cap,
	// bank select
	input  wire logic        sel_unit,
	// readback words
	output logic [31:0]      ns_word,
	output logic [31:0]      sec_word,
	output logic [31:0]      phase_word
);

	slot_state_t s_q;
	slot_state_t s_d;

	always_comb begin
		s_d = s_q;
		if (cap.valid) begin
			if (HAS_TIME) begin
				s_d.rising[cap.unit] = cap.rising;
				s_d.ns[cap.unit]     = cap.ns;
				s_d.sec[cap.unit]    = cap.sec;
			end
			case (cap.slot_idx)
				3'h0: s_d.code = `SLOT_CODE_0NS;
				3'h1: s_d.code = `SLOT_CODE_8NS;
				3'h2: s_d.code = `SLOT_CODE_16NS;
				3'h3: s_d.code = `SLOT_CODE_24NS;
				3'h4: s_d.code = `SLOT_CODE_32NS;
				default: s_d.code = s_q.code;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int u = 0; u < UNITS; u++) begin
				s_q.rising[u] <= 1'b0;
				s_q.ns[u]     <= `RST_NS;
				s_q.sec[u]    <= `RST_SEC;
			end
			s_q.code <= `RST_CODE;
		end else begin
			s_q <= s_d;
		end
	end

	// bank chosen by unit pointer
	assign ns_word    = {1'b0, s_q.rising[sel_unit], s_q.ns[sel_unit]};
	assign sec_word   = s_q.sec[sel_unit];
	assign phase_word = {29'h0000_0000, s_q.code};

endmodule : sample_slot

// [ts_store_params.svh]
// offsets, field positions, reset values and slot codes of the timestamp sample store
`ifndef TS_STORE_PARAMS_SVH
`define TS_STORE_PARAMS_SVH

`define OFS_S5_PHASE    12'h58C
`define OFS_S6_NS       12'h590
`define OFS_S6_SEC      12'h594
`define OFS_S6_PHASE    12'h598
`define OFS_S7_NS       12'h59C
`define OFS_S7_SEC      12'h5A0
`define OFS_UNIT_INDEX  12'h5FC

`define EDGE_BIT        30
`define NS_MSB          29
`define UNIT_PTR_BIT    8
`define UNIT_PTR_LANE   1

`define SLOT_CODE_0NS   3'h0
`define SLOT_CODE_8NS   3'h1
`define SLOT_CODE_16NS  3'h2
`define SLOT_CODE_24NS  3'h3
`define SLOT_CODE_32NS  3'h4

`define RST_NS          30'h0000_0000
`define RST_SEC         32'h0000_0000
`define RST_CODE        3'h0
`define RST_UNIT_PTR    1'h0

`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// [ts_store_pkg.sv]
// types shared by the timestamp sample store
package ts_store_pkg;

	localparam int UNITS = 2;

	typedef struct packed {
		logic        valid;
		logic        unit;
		logic        rising;
		logic [29:0] ns;
		logic [31:0] sec;
		logic [2:0]  slot_idx;
	} capture_t;

	typedef struct packed {
		logic [UNITS-1:0]       rising;
		logic [UNITS-1:0][29:0] ns;
		logic [UNITS-1:0][31:0] sec;
		logic [2:0]             code;
	} slot_state_t;

	typedef struct packed {
		logic        aw_got;
		logic        w_got;
		logic [11:0] addr;
		logic [31:0] data;
		logic [3:0]  strb;
		logic        bvalid;
		logic [1:0]  bresp;
	} wr_state_t;

	typedef enum logic {
		RD_IDLE,
		RD_RESP
	} rd_phase_t;

	typedef struct packed {
		rd_phase_t   phase;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        unit_ptr;
	} top_state_t;

endpackage : ts_store_pkg

// [ts_store_sva.sv]
// port assertions for the timestamp sample store
`include "ts_store_params.svh"
module ts_store_sva
	import ts_store_pkg::*;
(
	// clock, reset, write side
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        awvalid,
	input wire logic        awready,
	input wire logic [11:0] awaddr,
	input wire logic        wvalid,
	input wire logic        wready,
	input wire logic        bvalid,
	input wire logic [1:0]  bresp,
	// read side and pointer
	input wire logic        arvalid,
	input wire logic        arready,
	input wire logic [11:0] araddr,
	input wire logic        rvalid,
	input wire logic        rready,
	input wire logic [31:0] rdata,
	input wire logic [1:0]  rresp,
	input wire logic        unit_ptr
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic ar_hs;
	logic ph_rd;
	assign ar_hs = arvalid && arready;
	assign ph_rd = ar_hs && (araddr == `OFS_S5_PHASE || araddr == `OFS_S6_PHASE);

	a_read_answer: assert property (ar_hs |=> rvalid) else $error("read answer late");
	a_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("read lost");
	a_ar_refused: assert property (rvalid |-> !arready) else $error("read taken while busy");
	a_phase_upper_zero: assert property (ph_rd |=> rdata[31:3] == 29'h0) else $error("phase high bits");
	a_slot_code_range: assert property (ph_rd |=> rdata[2:0] <= 3'h4) else $error("slot code reserved");
	a_ns_top_zero: assert property (ar_hs && (araddr == `OFS_S6_NS || araddr == `OFS_S7_NS)
		|=> !rdata[31]) else $error("ns bit 31 set");
	a_ptr_on_write: assert property (!$stable(unit_ptr) |-> $rose(bvalid)) else $error("pointer moved");
	a_write_answer: assert property (awvalid && awready && wvalid && wready |=> bvalid)
		else $error("write answer late");
	a_sample_write_ok: assert property (awvalid && awready && wvalid && awaddr == `OFS_S6_SEC
		|=> bresp == `RESP_OKAY) else $error("sample write refused");
	a_unmapped_read: assert property (ar_hs && araddr == 12'h584
		|=> rresp == `RESP_SLVERR && rdata == 32'h0) else $error("unmapped read");
	cover property (rvalid && rready);
	cover property ($rose(unit_ptr));
	cover property (bvalid && bresp == `RESP_SLVERR);
endmodule : ts_store_sva

bind event_timestamp_sample_store ts_store_sva u_sva (.aclk, .aresetn, .awvalid, .awready, .awaddr,
	.wvalid, .wready, .bvalid, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .unit_ptr);
